// [hw/seiu_event_cell.sv]
`timescale 1ns/100ps
module seiu_event_cell (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ce,
    input  wire logic setEv,
    input  wire logic clrEv,
    output logic      evOut
);
    import seiu_pkg::*;

    typedef struct packed {
        logic ev;
    } seiu_cell_s;

    seiu_cell_s state_r;
    seiu_cell_s state_nxt;

    // sticky bit: set beats clear so a same-cycle event survives
    always_comb begin
        state_nxt = state_r;
        if (ce) begin
            if (setEv) begin
                state_nxt.ev = 1'b1;
            end else if (clrEv) begin
                state_nxt.ev = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign evOut = state_r.ev;

endmodule // seiu_event_cell

// [hw/seiu_event_unit.sv]
`timescale 1ns/100ps
module seiu_event_unit #(
    parameter int SPI_STATUS_W = seiu_pkg::SEIU_SPI_STATUS_W
) (
    input  wire logic                                 clk,
    input  wire logic                                 nrst,
    input  wire logic                                 ce,
    input  wire logic [seiu_pkg::SEIU_DATA_W-1:0]     statusFlags,
    input  wire logic [seiu_pkg::SEIU_NUM_PULSE-1:0]  eventPulse,
    input  wire logic [seiu_pkg::SEIU_ADDR_W-1:0]     regAddr,
    input  wire logic                                 regWrEn,
    input  wire logic [seiu_pkg::SEIU_DATA_W-1:0]     regWrData,
    input  wire logic                                 regRdEn,
    output logic      [seiu_pkg::SEIU_DATA_W-1:0]     regRdData,
    output logic      [SPI_STATUS_W-1:0]              spiStatus,
    output logic                                      intrOut
);
    import seiu_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [SEIU_DATA_W-1:0]  genCfg;
        logic [SEIU_DATA_W-1:0]  spiSel;
        logic [SEIU_DATA_W-1:0]  clrExempt;
        logic [SEIU_DATA_W-1:0]  intrMask;
        logic [SEIU_DATA_W-1:0]  prevFlags;
        logic [SEIU_DATA_W-1:0]  rdData;
        logic [SPI_STATUS_W-1:0] spiStatus;
        logic                    primed;
        logic                    intrOut;
    } seiu_state_s;

    seiu_state_s state_r;
    seiu_state_s state_nxt;

    logic [SEIU_DATA_W-1:0] evVec;    // sticky events from the cells
    logic [SEIU_DATA_W-1:0] setVec;   // events raised this cycle
    logic [SEIU_DATA_W-1:0] clrVec;   // events cleared this cycle
    logic [SEIU_DATA_W-1:0] flagDiff;
    logic [SEIU_VEL_W-1:0]  velNow;
    logic [SEIU_VEL_W-1:0]  velPrev;
    logic                   rdEvents;
    logic                   wrEvents;
    logic                   intrAct;

    // ------------------------------------------------------------------
    // status byte selection
    // ------------------------------------------------------------------
    // walk upward from index 0 and fill slots in order until all are used
    function automatic logic [SPI_STATUS_W-1:0] pickStatus(
        input logic [SEIU_DATA_W-1:0] ev,
        input logic [SEIU_DATA_W-1:0] sel
    );
        logic [SPI_STATUS_W-1:0] res;
        int                      slot;
        res  = '0;
        slot = 0;
        for (int i = 0; i < SEIU_DATA_W; i++) begin
            if (sel[i] && (slot < SPI_STATUS_W)) begin
                res[slot] = ev[i];
                slot++;
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // event sources
    // ------------------------------------------------------------------
    // until the first enabled cycle the previous flags are unknown, so
    // change detection is held off to avoid spurious events after reset
    always_comb begin
        velNow   = statusFlags[SEIU_VEL_LSB +: SEIU_VEL_W];
        velPrev  = state_r.prevFlags[SEIU_VEL_LSB +: SEIU_VEL_W];
        flagDiff = statusFlags ^ state_r.prevFlags;
        setVec   = '0;
        setVec[SEIU_EV_VEL_LSB + 0] = state_r.primed && (velNow == SEIU_VEL_CODE_0)
                                      && (velPrev != SEIU_VEL_CODE_0);
        setVec[SEIU_EV_VEL_LSB + 1] = state_r.primed && (velNow == SEIU_VEL_CODE_1)
                                      && (velPrev != SEIU_VEL_CODE_1);
        setVec[SEIU_EV_VEL_LSB + 2] = state_r.primed && (velNow == SEIU_VEL_CODE_2)
                                      && (velPrev != SEIU_VEL_CODE_2);
        if (state_r.primed) begin
            setVec[SEIU_EV_FLAG_LSB +: SEIU_NUM_FLAG_EV] =
                flagDiff[SEIU_FLAG_LSB +: SEIU_NUM_FLAG_EV];
        end
        setVec[SEIU_EV_PULSE_LSB +: SEIU_NUM_PULSE] = eventPulse;
    end

    // ------------------------------------------------------------------
    // clearing paths
    // ------------------------------------------------------------------
    // read clears only what it returns; a new event in the same cycle wins
    // in the cell, so nothing raised during the read is dropped
    always_comb begin
        rdEvents = ce && regRdEn && (regAddr == SEIU_ADDR_EVENTS);
        wrEvents = ce && regWrEn && (regAddr == SEIU_ADDR_EVENTS);
        clrVec   = '0;
        if (rdEvents) begin
            clrVec = evVec & ~state_r.clrExempt;
        end
        if (wrEvents) begin
            clrVec = clrVec | regWrData;
        end
    end

    // ------------------------------------------------------------------
    // event latches
    // ------------------------------------------------------------------
    // one sticky cell per event bit
    for (genvar g = 0; g < SEIU_DATA_W; g++) begin : gEvent
        seiu_event_cell uCell (
            .clk   (clk),
            .nrst  (nrst),
            .ce    (ce),
            .setEv (setVec[g]),
            .clrEv (clrVec[g]),
            .evOut (evVec[g])
        );
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        intrAct   = |(evVec & state_r.intrMask);
        if (ce) begin
            state_nxt.primed    = 1'b1;
            state_nxt.prevFlags = statusFlags;
            state_nxt.spiStatus = pickStatus(evVec, state_r.spiSel);
            // polarity bit low gives the idle-high, active-low pin
            state_nxt.intrOut   = state_r.genCfg[SEIU_CFG_INTR_POL_BIT] ? intrAct
                                                                        : ~intrAct;
            if (regWrEn) begin
                case (regAddr)
                    SEIU_ADDR_GEN_CFG: state_nxt.genCfg    = regWrData;
                    SEIU_ADDR_SPI_SEL: state_nxt.spiSel    = regWrData;
                    SEIU_ADDR_EXEMPT:  state_nxt.clrExempt = regWrData;
                    SEIU_ADDR_INTR_MK: state_nxt.intrMask  = regWrData;
                    default:           state_nxt.genCfg    = state_r.genCfg;
                endcase
            end
            if (regRdEn) begin
                case (regAddr)
                    SEIU_ADDR_GEN_CFG: state_nxt.rdData = state_r.genCfg;
                    SEIU_ADDR_SPI_SEL: state_nxt.rdData = state_r.spiSel;
                    SEIU_ADDR_EXEMPT:  state_nxt.rdData = state_r.clrExempt;
                    SEIU_ADDR_INTR_MK: state_nxt.rdData = state_r.intrMask;
                    SEIU_ADDR_EVENTS:  state_nxt.rdData = evVec;
                    SEIU_ADDR_FLAGS:   state_nxt.rdData = statusFlags;
                    default:           state_nxt.rdData = SEIU_REG_RST;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r         <= '0;
            state_r.intrOut <= SEIU_INTR_IDLE_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs straight from flops
    assign regRdData = state_r.rdData;
    assign spiStatus = state_r.spiStatus;
    assign intrOut   = state_r.intrOut;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // every raised event is held in the next cycle
    a_event_set_sticky: assert property (
        ce |=> ((evVec & $past(setVec)) == $past(setVec)))
        else $error("raised event not latched");

    // an event neither read nor written stays set
    a_event_holds: assert property (
        (!rdEvents && !wrEvents) |=> ((evVec & $past(evVec)) == $past(evVec)))
        else $error("event dropped without a clear");

    // a change of the lowest plain flag raises its mapped event
    a_flag_change_event: assert property (
        (ce && state_r.primed && flagDiff[SEIU_FLAG_LSB]) |=> evVec[SEIU_EV_FLAG_LSB])
        else $error("flag change event missing");

    // code one entering sets its own event
    a_vel_code_one: assert property (
        (ce && state_r.primed && velNow == SEIU_VEL_CODE_1 && velPrev != SEIU_VEL_CODE_1)
        |=> evVec[SEIU_EV_VEL_LSB + 1])
        else $error("velocity code one event missing");

    // code zero entering sets its own event
    a_vel_code_zero: assert property (
        (ce && state_r.primed && velNow == SEIU_VEL_CODE_0 && velPrev != SEIU_VEL_CODE_0)
        |=> evVec[SEIU_EV_VEL_LSB])
        else $error("velocity code zero event missing");

    // code two entering sets its own event
    a_vel_code_two: assert property (
        (ce && state_r.primed && velNow == SEIU_VEL_CODE_2 && velPrev != SEIU_VEL_CODE_2)
        |=> evVec[SEIU_EV_VEL_LSB + 2])
        else $error("velocity code two event missing");

    // a code that stays put raises no event for it
    a_vel_code_steady: assert property (
        (state_r.primed && velNow == velPrev)
        |-> (setVec[SEIU_EV_VEL_LSB +: SEIU_NUM_VEL_EV] == '0))
        else $error("velocity event on steady code");

    // live flags read back unchanged one edge on
    a_flags_live_read: assert property (
        (ce && regRdEn && regAddr == SEIU_ADDR_FLAGS) |=> (regRdData == $past(statusFlags)))
        else $error("live flags read mismatch");

    // pulse input 0 lands in event bit 24, the lowest pulse event bit
    a_pulse_event_set: assert property (
        (ce && eventPulse[0]) |=> evVec[SEIU_EV_PULSE_LSB])
        else $error("pulse event not latched");

    // every pulse input lands in its own event bit
    a_pulse_all_set: assert property (
        ce |=> ((evVec[SEIU_EV_PULSE_LSB +: SEIU_NUM_PULSE] & $past(eventPulse))
        == $past(eventPulse)))
        else $error("pulse event bits not latched");

    // read returns prior events and clears returned, non-exempt bits
    a_read_clears_events: assert property (
        rdEvents |=> (regRdData == $past(evVec))
        && ((evVec & $past(evVec & ~state_r.clrExempt & ~setVec)) == '0))
        else $error("clear on read wrong");

    // an event raised in the read cycle outlives the clear
    a_read_race_kept: assert property (
        rdEvents |=> ((evVec & $past(setVec)) == $past(setVec)))
        else $error("event lost at clear on read");

    // exempt events survive a read
    a_read_keeps_exempt: assert property (
        (rdEvents && !wrEvents) |=> ((evVec & $past(evVec & state_r.clrExempt))
        == $past(evVec & state_r.clrExempt)))
        else $error("exempt event cleared by read");

    // write one clears unless raised again
    a_write_one_clears: assert property (
        wrEvents |=> ((evVec & $past(regWrData & ~setVec)) == '0))
        else $error("write one did not clear");

    // all selected: status byte mirrors the lowest events
    a_spi_all_selected: assert property (
        (ce && (&state_r.spiSel)) |=> (spiStatus == $past(evVec[SPI_STATUS_W-1:0])))
        else $error("status byte order wrong");

    // a single selected high event moves into slot zero
    a_spi_single_select: assert property (
        (ce && state_r.spiSel == 32'h8000_0000) |=> (spiStatus[0] == $past(evVec[31])))
        else $error("selected event not in status");

    // an empty selection leaves the status byte clear
    a_spi_none_selected: assert property (
        (ce && state_r.spiSel == '0) |=> (spiStatus == '0))
        else $error("status byte set with empty selection");

    // a mask write lands at the next edge
    a_mask_write_lands: assert property (
        (ce && regWrEn && regAddr == SEIU_ADDR_INTR_MK)
        |=> (state_r.intrMask == $past(regWrData)))
        else $error("interrupt mask write lost");

    // enabled event with default polarity pulls the pin low
    a_intr_active_low: assert property (
        (ce && intrAct && !state_r.genCfg[SEIU_CFG_INTR_POL_BIT]) |=> !intrOut)
        else $error("interrupt not asserted low");

    // no enabled event with high polarity keeps the pin low
    a_intr_pol_high: assert property (
        (ce && !intrAct && state_r.genCfg[SEIU_CFG_INTR_POL_BIT]) |=> !intrOut)
        else $error("interrupt polarity wrong");

    // no enabled event with default polarity keeps the pin high
    a_intr_idle_high: assert property (
        (ce && !intrAct && !state_r.genCfg[SEIU_CFG_INTR_POL_BIT]) |=> intrOut)
        else $error("idle interrupt not high");

    // enabled event with high polarity drives the pin high
    a_intr_act_high: assert property (
        (ce && intrAct && state_r.genCfg[SEIU_CFG_INTR_POL_BIT]) |=> intrOut)
        else $error("interrupt not asserted high");

    c_read_clear: cover property (rdEvents && (evVec != '0));
    c_write_clear: cover property (wrEvents && ((evVec & regWrData) != '0));
    c_intr_fire: cover property (ce && intrAct);
    c_vel_event: cover property (ce && setVec[SEIU_EV_VEL_LSB + 2]);
    c_exempt_kept: cover property (rdEvents && ((evVec & state_r.clrExempt) != '0));

endmodule // seiu_event_unit

// [hw/seiu_pkg.sv]
package seiu_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int SEIU_DATA_W       = 32;
    localparam int SEIU_ADDR_W       = 7;
    localparam int SEIU_SPI_STATUS_W = 8;
    localparam int SEIU_VEL_W        = 2;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [SEIU_ADDR_W-1:0] SEIU_ADDR_GEN_CFG = 7'h00;
    localparam logic [SEIU_ADDR_W-1:0] SEIU_ADDR_SPI_SEL = 7'h0b;
    localparam logic [SEIU_ADDR_W-1:0] SEIU_ADDR_EXEMPT  = 7'h0c;
    localparam logic [SEIU_ADDR_W-1:0] SEIU_ADDR_INTR_MK = 7'h0d;
    localparam logic [SEIU_ADDR_W-1:0] SEIU_ADDR_EVENTS  = 7'h0e;
    localparam logic [SEIU_ADDR_W-1:0] SEIU_ADDR_FLAGS   = 7'h0f;

    // ------------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------------
    localparam int                     SEIU_CFG_INTR_POL_BIT = 29;
    localparam logic [SEIU_DATA_W-1:0] SEIU_REG_RST          = 32'h0000_0000;
    localparam logic                   SEIU_INTR_IDLE_RST    = 1'h1;

    // ------------------------------------------------------------------
    // event map
    // ------------------------------------------------------------------
    localparam int SEIU_VEL_LSB      = 0;  // velocity state flag position
    localparam int SEIU_EV_VEL_LSB   = 0;  // three velocity code events
    localparam int SEIU_NUM_VEL_EV   = 3;
    localparam int SEIU_FLAG_LSB     = 2;  // first flag with a change event
    localparam int SEIU_EV_FLAG_LSB  = 3;
    localparam int SEIU_NUM_FLAG_EV  = 21;
    localparam int SEIU_EV_PULSE_LSB = 24; // events without a status flag
    localparam int SEIU_NUM_PULSE    = 8;

    localparam logic [SEIU_VEL_W-1:0] SEIU_VEL_CODE_0 = 2'h0;
    localparam logic [SEIU_VEL_W-1:0] SEIU_VEL_CODE_1 = 2'h1;
    localparam logic [SEIU_VEL_W-1:0] SEIU_VEL_CODE_2 = 2'h2;

endpackage

// [test/seiu_host_model.sv]
`timescale 1ns/100ps
module seiu_host_model (
    input  wire logic                             clk,
    input  wire logic [seiu_pkg::SEIU_DATA_W-1:0] regRdData,
    output logic      [seiu_pkg::SEIU_ADDR_W-1:0] regAddr,
    output logic                                  regWrEn,
    output logic      [seiu_pkg::SEIU_DATA_W-1:0] regWrData,
    output logic                                  regRdEn
);
    import seiu_pkg::*;

    // idle bus at time zero, strobes low
    initial begin
        regAddr   = '0;
        regWrEn   = 1'b0;
        regWrData = '0;
        regRdEn   = 1'b0;
    end

    // released lines show the inverse, so a stale value never passes as valid
    task automatic park;
        regAddr   = ~regAddr;
        regWrData = ~regWrData;
    endtask

    // one write; waits an edge first so back to back calls never clash
    task automatic wr_reg(input logic [SEIU_ADDR_W-1:0] a, input logic [SEIU_DATA_W-1:0] d);
        @(posedge clk);
        #1;
        regAddr   = a;
        regWrData = d;
        regWrEn   = 1'b1;
        @(posedge clk);
        #1;
        regWrEn = 1'b0;
        park();
    endtask

    // one read; data is taken just after the edge that accepts it
    task automatic rd_reg(input logic [SEIU_ADDR_W-1:0] a, output logic [SEIU_DATA_W-1:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge clk);
        #1;
        d       = regRdData;
        regRdEn = 1'b0;
        park();
    endtask

    // start-up read that empties stale events before regular work
    task automatic flush_events;
        logic [SEIU_DATA_W-1:0] d;
        rd_reg(SEIU_ADDR_EVENTS, d);
    endtask
endmodule // seiu_host_model

// [test/tb.sv]
`timescale 1ns/100ps
module tb;
    import seiu_pkg::*;

    // ------------------------------
    // design, host and clock
    // ------------------------------
    logic                         clk;
    logic                         nrst;
    logic                         ce;
    logic [SEIU_DATA_W-1:0]       statusFlags;
    logic [SEIU_NUM_PULSE-1:0]    eventPulse;
    logic [SEIU_ADDR_W-1:0]       regAddr;
    logic                         regWrEn;
    logic [SEIU_DATA_W-1:0]       regWrData;
    logic                         regRdEn;
    logic [SEIU_DATA_W-1:0]       regRdData;
    logic [SEIU_SPI_STATUS_W-1:0] spiStatus;
    logic                         intrOut;
    int                           mismatches;
    int                           cmpCount;
    logic [SEIU_ADDR_W-1:0]       regList [6] = '{SEIU_ADDR_GEN_CFG, SEIU_ADDR_SPI_SEL,
        SEIU_ADDR_EXEMPT, SEIU_ADDR_INTR_MK, SEIU_ADDR_EVENTS, SEIU_ADDR_FLAGS};

    seiu_event_unit uut (
        .clk(clk), .nrst(nrst), .ce(ce), .statusFlags(statusFlags),
        .eventPulse(eventPulse), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .spiStatus(spiStatus), .intrOut(intrOut)
    );

    seiu_host_model host (
        .clk(clk), .regRdData(regRdData), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn)
    );

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------
    // helpers
    // ------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk_word(input string w, input logic [31:0] e, input logic [31:0] g);
        cmpCount++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", w, e, g);
        end
    endtask

    task automatic chk_pin(input string w, input logic [7:0] e, input logic [7:0] g);
        cmpCount++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", w, e, g);
        end
    endtask

    task automatic rd_chk(input string w, input logic [6:0] a, input logic [31:0] e);
        logic [31:0] d;
        host.rd_reg(a, d);
        chk_word(w, e, d);
    endtask

    task automatic report_and_stop;
        $display("compares %0d, mismatches %0d", cmpCount, mismatches);
        if (mismatches == 0 && cmpCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic test_reset;
        chk_pin("idle intrOut", 8'h01, {7'h0, intrOut});
        chk_pin("idle spiStatus", 8'h00, spiStatus);
        host.flush_events();
        foreach (regList[i]) rd_chk("reset register", regList[i], SEIU_REG_RST);
        rd_chk("unmapped read", 7'h05, 32'h0);
        ce = 1'b0;
        host.wr_reg(SEIU_ADDR_SPI_SEL, 32'h1);
        ce = 1'b1;
        rd_chk("frozen write", SEIU_ADDR_SPI_SEL, 32'h0);
        host.wr_reg(SEIU_ADDR_FLAGS, 32'hffff_ffff);
        rd_chk("read-only flags", SEIU_ADDR_FLAGS, 32'h0);
        $display("test reset done");
    endtask

    // flags 1:0 are the velocity code, flag 5 feeds event 6, flag 30 has none
    task automatic test_events;
        statusFlags = 32'h4000_0021;
        tick(2);
        rd_chk("live flags", SEIU_ADDR_FLAGS, 32'h4000_0021);
        rd_chk("first events", SEIU_ADDR_EVENTS, 32'h0000_0042);
        rd_chk("after read", SEIU_ADDR_EVENTS, 32'h0);
        statusFlags = 32'h4000_0022;
        tick(2);
        rd_chk("code 10 only", SEIU_ADDR_EVENTS, 32'h0000_0004);
        statusFlags = 32'h0;
        tick(2);
        rd_chk("code 00 and fall", SEIU_ADDR_EVENTS, 32'h0000_0041);
        $display("test events done");
    endtask

    // pulse events have no flag; a pulse meeting the read must survive it
    task automatic test_exempt;
        logic [31:0] d;
        host.wr_reg(SEIU_ADDR_EXEMPT, 32'h0100_0000);
        eventPulse = 8'h01;
        tick(1);
        eventPulse = 8'h00;
        rd_chk("pulse event", SEIU_ADDR_EVENTS, 32'h0100_0000);
        fork
            host.rd_reg(SEIU_ADDR_EVENTS, d);
            begin
                tick(1);
                eventPulse = 8'h02;
            end
        join
        eventPulse = 8'h00;
        chk_word("race read", 32'h0100_0000, d);
        rd_chk("late event kept", SEIU_ADDR_EVENTS, 32'h0300_0000);
        rd_chk("exempt stays", SEIU_ADDR_EVENTS, 32'h0100_0000);
        host.wr_reg(SEIU_ADDR_EVENTS, 32'hffff_ffff);
        rd_chk("write clear", SEIU_ADDR_EVENTS, 32'h0);
        host.wr_reg(SEIU_ADDR_EXEMPT, 32'h0);
        $display("test exempt done");
    endtask

    // nine selected: event 3 and 24..31, so event 31 falls off the byte
    task automatic test_spi;
        host.wr_reg(SEIU_ADDR_SPI_SEL, 32'hff00_0008);
        statusFlags = 32'h4;
        eventPulse  = 8'hfe;
        tick(1);
        eventPulse = 8'h00;
        tick(2);
        chk_pin("status byte", 8'hfd, spiStatus);
        rd_chk("selected events", SEIU_ADDR_EVENTS, 32'hfe00_0008);
        tick(1);
        chk_pin("byte after read", 8'h00, spiStatus);
        // only the top event selected: it moves down into slot zero
        host.wr_reg(SEIU_ADDR_SPI_SEL, 32'h8000_0000);
        statusFlags = 32'h0;
        eventPulse  = 8'h80;
        tick(1);
        eventPulse = 8'h00;
        tick(2);
        chk_pin("top event slot", 8'h01, spiStatus);
        host.wr_reg(SEIU_ADDR_SPI_SEL, 32'hffff_ffff);
        tick(1);
        chk_pin("all selected", 8'h08, spiStatus);
        rd_chk("spi events", SEIU_ADDR_EVENTS, 32'h8000_0008);
        host.wr_reg(SEIU_ADDR_SPI_SEL, 32'h0);
        $display("test spi done");
    endtask

    task automatic test_intr;
        host.wr_reg(SEIU_ADDR_INTR_MK, 32'h0000_0040);
        statusFlags = statusFlags ^ 32'h40;
        tick(2);
        chk_pin("masked event", 8'h01, {7'h0, intrOut});
        statusFlags = statusFlags ^ 32'h20;
        tick(2);
        chk_pin("enabled event", 8'h00, {7'h0, intrOut});
        host.wr_reg(SEIU_ADDR_GEN_CFG, 32'h2000_0000);
        tick(1);
        chk_pin("high polarity", 8'h01, {7'h0, intrOut});
        rd_chk("config back", SEIU_ADDR_GEN_CFG, 32'h2000_0000);
        rd_chk("intr events", SEIU_ADDR_EVENTS, 32'h0000_00c0);
        tick(1);
        chk_pin("idle high pol", 8'h00, {7'h0, intrOut});
        $display("test intr done");
    endtask

    // main sequence; inputs move 1 ns after the rising edge
    initial begin
        mismatches  = 0;
        cmpCount    = 0;
        nrst        = 1'b0;
        ce          = 1'b1;
        statusFlags = '0;
        eventPulse  = '0;
        repeat (16) @(posedge clk);
        #1;
        nrst = 1'b1;
        tick(2);
        test_reset();
        test_events();
        test_exempt();
        test_spi();
        test_intr();
        report_and_stop();
    end

    // the run needs about 110 cycles; some eighteen times that means a hang
    initial begin
        #8000;
        mismatches++;
        $display("unexpected run length: expected end by 8000 ns, seen timeout");
        report_and_stop();
    end
endmodule // tb
